// ==== rtl/alu_params.svh ====
// constants for the cpu alu, status word and divider datapath
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

// status word field positions
`define FW_HALF_CARRY_BIT 8
`define FW_PRIO_HI_BIT 7
`define FW_PRIO_LO_BIT 5
`define FW_REPEAT_BIT 4
`define FW_NEG_BIT 3
`define FW_WRAP_BIT 2
`define FW_ZERO_BIT 1
`define FW_CARRY_BIT 0
`define FW_RESET 16'h0000
`define FW_IMPL_MASK 16'h01ff

// control word field positions
`define CC_PRIO_UPPER_BIT 3
`define CC_PROG_WINDOW_BIT 2
`define CC_RESET 16'h0000

// priority level at which user interrupts stop
`define PRIO_LOW_MAX 3'h7

// divider timing: one load, sixteen steps, one fix, one write
`define DIV_CYCLES 19
`define DIV_STEPS 5'h10
`define DIV_LAST_STEP 5'h0f

// program address forming
`define PROG_ADDR_W 24
`define IP_W 23
`define TBL_UPPER_BIT 7

`endif

// ==== rtl/alu_pkg.sv ====
// types shared by the cpu alu datapath and its users
package alu_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD,
    OP_ADDC,
    OP_SUB,
    OP_SUBB,
    OP_AND,
    OP_IOR,
    OP_XOR,
    OP_ARITH_RIGHT_SHIFT,
    OP_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT
  } alu_op_t;

  typedef enum logic [2:0] {
    MUL_SS,
    MUL_UU,
    MUL_SU,
    MUL_US,
    MUL_S_LIT,
    MUL_U_LIT,
    MUL_BYTE_UU
  } mul_mode_t;

  typedef enum logic [1:0] {
    DIV_IDLE,
    DIV_ITER,
    DIV_FIX,
    DIV_WRITE
  } div_state_t;

endpackage

// ==== rtl/cpu_alu_status_datapath.sv ====
// cpu alu, status and control words, multiplier, divider, address forming
// Notes on behaviour
// - half carry from bit 3 byte, bit 7 word
// - status bits 7:5 hold priority zero to seven
// - priority is upper bit over three low bits
// - nesting disable makes priority bits read-only
// - repeat flag follows hardware loop, read-only
// - negative flag copies result sign bit
// - wrap flag marks signed overflow
// - zero flag cleared by non-zero results
// - carry flag is carry out of msb
// - subtract carries act as inverted borrows
// - upper bit set above seven, software clears
// - program window enable, resets to zero
// - add, subtract, shift, logic at byte/word
// - seventeen by seventeen bit multiplier
// - signed, unsigned, mixed, literal and byte multiply
// - signed/unsigned 32 or 16 by 16 divide
// - quotient to register zero, remainder to one
// - long dividend from aligned pair, odd high
// - one divide step per divisor bit
// - divide takes fixed cycles, pausable
// - shift up to fifteen in one cycle
// - shifts use register operands only
// - arithmetic right, left, logical right shifts
// - 24-bit addresses, user lower half only
// - table page bit 7 reaches upper half
// - multiply completes in one cycle
`timescale 1ns/100ps
`default_nettype none
`include "alu_params.svh"

module cpu_alu_status_datapath (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // alu operation, operands read from working registers
  input wire logic i_op_valid,
  input wire alu_pkg::alu_op_t i_op,
  input wire logic i_byte_mode,
  input wire logic [15:0] i_op_a,
  input wire logic [15:0] i_op_b,
  input wire logic [3:0] i_shift_amount,
  output logic [15:0] o_result_q,
  output logic o_result_valid_q,
  // multiplier
  input wire logic i_mul_valid,
  input wire alu_pkg::mul_mode_t i_mul_mode,
  input wire logic [15:0] i_mul_a,
  input wire logic [15:0] i_mul_b,
  input wire logic [4:0] i_mul_literal,
  output logic [31:0] o_product_q,
  output logic o_product_valid_q,
  // divider
  input wire logic i_div_start,
  input wire logic i_div_signed,
  input wire logic i_div_long,
  input wire logic i_div_hold,
  input wire logic [15:0] i_dividend_even,
  input wire logic [15:0] i_dividend_odd,
  input wire logic [15:0] i_divisor,
  output logic o_div_busy_q,
  output logic o_div_done_q,
  output logic [15:0] o_quotient_register_q,
  output logic [15:0] o_remainder_register_q,
  // status and control word access
  input wire logic i_flags_write,
  input wire logic [15:0] i_flags_wdata,
  input wire logic i_control_write,
  input wire logic [15:0] i_control_wdata,
  output logic [15:0] o_alu_flags_word_q,
  output logic [15:0] o_core_control_word_q,
  // priority from the interrupt side
  input wire logic i_nesting_disable,
  input wire logic i_repeat_active,
  input wire logic i_hw_priority_write,
  input wire logic [3:0] i_hw_priority,
  output logic [3:0] o_cpu_priority_q,
  output logic o_user_irq_blocked_q,
  // program address forming
  input wire logic [22:0] i_instruction_pointer,
  input wire logic i_table_access,
  input wire logic [7:0] i_table_page_register,
  input wire logic [15:0] i_table_offset,
  input wire logic i_window_access,
  input wire logic [7:0] i_window_page,
  input wire logic [14:0] i_window_offset,
  output logic [23:0] o_prog_addr_q,
  output logic o_prog_addr_ok_q
);
  import alu_pkg::*;

  // ----------------------------------------------------------------
  // alu arithmetic and logic
  // ----------------------------------------------------------------
  logic [15:0] flags_q;
  logic [15:0] control_q;
  wire carry_now = flags_q[`FW_CARRY_BIT];
  wire is_sub = (i_op == OP_SUB) || (i_op == OP_SUBB);
  wire is_arith = is_sub || (i_op == OP_ADD) || (i_op == OP_ADDC);
  wire is_chain = (i_op == OP_ADDC) || (i_op == OP_SUBB);
  wire is_logic = (i_op == OP_AND) || (i_op == OP_IOR) ||
                  (i_op == OP_XOR);
  wire is_shift = (i_op == OP_ARITH_RIGHT_SHIFT) ||
                  (i_op == OP_LEFT_SHIFT) ||
                  (i_op == OP_LOGICAL_RIGHT_SHIFT);
  // subtract adds the inverse, so carry out reads as "no borrow"
  wire [15:0] b_eff = is_sub ? ~i_op_b : i_op_b;
  wire cin = is_chain ? carry_now : is_sub;
  wire [4:0] sum_lo = {1'b0, i_op_a[3:0]} + {1'b0, b_eff[3:0]} +
                      {4'h0, cin};
  wire [4:0] sum_mid = {1'b0, i_op_a[7:4]} + {1'b0, b_eff[7:4]} +
                       {4'h0, sum_lo[4]};
  wire [8:0] sum_hi = {1'b0, i_op_a[15:8]} + {1'b0, b_eff[15:8]} +
                      {8'h00, sum_mid[4]};
  wire [15:0] sum = {sum_hi[7:0], sum_mid[3:0], sum_lo[3:0]};
  wire add_half = i_byte_mode ? sum_lo[4] : sum_mid[4];
  wire add_carry = i_byte_mode ? sum_mid[4] : sum_hi[8];
  wire sign_a = i_byte_mode ? i_op_a[7] : i_op_a[15];
  wire sign_b = i_byte_mode ? b_eff[7] : b_eff[15];
  wire sign_s = i_byte_mode ? sum[7] : sum[15];
  wire add_wrap = (sign_a == sign_b) && (sign_s != sign_a);

  wire [15:0] logic_res = (i_op == OP_AND) ? (i_op_a & i_op_b) :
                          (i_op == OP_IOR) ? (i_op_a | i_op_b) :
                          (i_op_a ^ i_op_b);

  // ----------------------------------------------------------------
  // barrel shifter, one cycle for any count up to fifteen
  // ----------------------------------------------------------------
  wire fill_bit = (i_op == OP_ARITH_RIGHT_SHIFT) & i_op_a[7];
  wire [15:0] shift_src = i_byte_mode ?
                          {{8{fill_bit}}, i_op_a[7:0]} : i_op_a;
  wire [15:0] right_ar_res = 16'($signed(shift_src) >>> i_shift_amount);
  wire [15:0] right_lg_res = shift_src >> i_shift_amount;
  wire [15:0] left_res = i_op_a << i_shift_amount;
  wire [15:0] shift_res = (i_op == OP_LEFT_SHIFT) ? left_res :
                          (i_op == OP_ARITH_RIGHT_SHIFT) ? right_ar_res :
                          right_lg_res;
  // only a single-bit shift reports the bit pushed out
  wire shift_single = (i_shift_amount == 4'h1);
  wire shift_out = (i_op == OP_LEFT_SHIFT) ?
                   (i_byte_mode ? i_op_a[7] : i_op_a[15]) : i_op_a[0];

  wire [15:0] raw_res = is_arith ? sum : is_logic ? logic_res :
                        is_shift ? shift_res : i_op_a;
  // byte results leave the upper byte of the destination alone
  wire [15:0] op_res = i_byte_mode ?
                       {i_op_a[15:8], raw_res[7:0]} : raw_res;
  wire res_neg = i_byte_mode ? raw_res[7] : raw_res[15];
  wire res_zero = i_byte_mode ? (raw_res[7:0] == 8'h00) :
                  (raw_res == 16'h0000);
  wire alu_go = i_op_valid && (i_op != OP_NONE);
  wire aff_nz = alu_go && (is_arith || is_logic || is_shift);
  wire aff_arith = alu_go && is_arith;
  wire aff_shc = alu_go && is_shift && shift_single;

  // ----------------------------------------------------------------
  // status word next value
  // ----------------------------------------------------------------
  wire sw_prio_ok = i_flags_write && !i_nesting_disable;
  wire [15:0] flags_sw = i_flags_write ? i_flags_wdata : flags_q;
  wire [2:0] prio_low_d = i_hw_priority_write ? i_hw_priority[2:0] :
                          sw_prio_ok ?
                          i_flags_wdata[`FW_PRIO_HI_BIT:`FW_PRIO_LO_BIT] :
                          flags_q[`FW_PRIO_HI_BIT:`FW_PRIO_LO_BIT];
  // hardware results win over a software write in the same cycle
  wire half_d = aff_arith ? add_half :
                flags_sw[`FW_HALF_CARRY_BIT];
  wire neg_d = aff_nz ? res_neg : flags_sw[`FW_NEG_BIT];
  wire wrap_d = aff_arith ? add_wrap : flags_sw[`FW_WRAP_BIT];
  // chained ops only ever clear zero, so a long result tests as one
  wire zero_d = !aff_nz ? flags_sw[`FW_ZERO_BIT] :
                is_chain ? (flags_q[`FW_ZERO_BIT] & res_zero) :
                res_zero;
  wire carry_d = aff_arith ? add_carry : aff_shc ? shift_out :
                 flags_sw[`FW_CARRY_BIT];
  wire [15:0] flags_d = {7'h00, half_d, prio_low_d, i_repeat_active,
                         neg_d, wrap_d, zero_d, carry_d};

  // ----------------------------------------------------------------
  // control word next value
  // ----------------------------------------------------------------
  // software may clear the upper priority bit but never set it
  wire upper_sw = i_control_write ?
                  (control_q[`CC_PRIO_UPPER_BIT] &
                   i_control_wdata[`CC_PRIO_UPPER_BIT]) :
                  control_q[`CC_PRIO_UPPER_BIT];
  wire upper_d = i_hw_priority_write ? i_hw_priority[3] :
                 upper_sw;
  wire window_d = i_control_write ?
                  i_control_wdata[`CC_PROG_WINDOW_BIT] :
                  control_q[`CC_PROG_WINDOW_BIT];
  wire [15:0] control_d = {12'h000, upper_d, window_d, 2'b00};
  wire [3:0] prio_d = {upper_d, prio_low_d};
  wire blocked_d = upper_d || (prio_low_d == `PRIO_LOW_MAX);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      flags_q <= `FW_RESET;
      control_q <= `CC_RESET;
      o_cpu_priority_q <= 4'h0;
      o_user_irq_blocked_q <= 1'b0;
    end else begin
      flags_q <= flags_d & `FW_IMPL_MASK;
      control_q <= control_d;
      o_cpu_priority_q <= prio_d;
      o_user_irq_blocked_q <= blocked_d;
    end
  end
  assign o_alu_flags_word_q = flags_q;
  assign o_core_control_word_q = control_q;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_result_q <= 16'h0000;
      o_result_valid_q <= 1'b0;
    end else begin
      o_result_q <= op_res;
      o_result_valid_q <= alu_go;
    end
  end

  // ----------------------------------------------------------------
  // multiplier: both operands widened to 17 bits with a sign bit
  // ----------------------------------------------------------------
  wire a_signed = (i_mul_mode == MUL_SS) || (i_mul_mode == MUL_SU) ||
                  (i_mul_mode == MUL_S_LIT);
  wire b_signed = (i_mul_mode == MUL_SS) || (i_mul_mode == MUL_US);
  wire lit_mode = (i_mul_mode == MUL_S_LIT) ||
                  (i_mul_mode == MUL_U_LIT);
  wire byte_mul = (i_mul_mode == MUL_BYTE_UU);
  wire [15:0] mul_a_src = byte_mul ? {8'h00, i_mul_a[7:0]} : i_mul_a;
  wire [15:0] mul_b_src = lit_mode ? {11'h000, i_mul_literal} :
                          byte_mul ? {8'h00, i_mul_b[7:0]} :
                          i_mul_b;
  wire [16:0] mul_a17 = {a_signed & mul_a_src[15], mul_a_src};
  wire [16:0] mul_b17 = {b_signed & mul_b_src[15], mul_b_src};
  wire [33:0] mul_full = 34'($signed(mul_a17) * $signed(mul_b17));

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_product_q <= 32'h00000000;
      o_product_valid_q <= 1'b0;
    end else begin
      if (i_mul_valid) begin
        o_product_q <= mul_full[31:0];
      end
      o_product_valid_q <= i_mul_valid;
    end
  end

  // ----------------------------------------------------------------
  // divider: restoring steps on magnitudes, signs fixed at the end
  // ----------------------------------------------------------------
  div_state_t div_state_q;
  logic [4:0] step_q;
  logic [15:0] rem_q;
  logic [15:0] num_q;
  logic [15:0] den_q;
  logic neg_num_q;
  logic neg_den_q;

  wire [15:0] even_ext = (i_div_signed & i_dividend_even[15]) ?
                         16'hffff : 16'h0000;
  wire [31:0] dvd = i_div_long ?
                    {i_dividend_odd, i_dividend_even} :
                    {even_ext, i_dividend_even};
  wire dvd_neg = i_div_signed & dvd[31];
  wire dsr_neg = i_div_signed & i_divisor[15];
  wire [31:0] dvd_mag = dvd_neg ? (~dvd + 32'h00000001) : dvd;
  wire [15:0] dsr_mag = dsr_neg ? (~i_divisor + 16'h0001) : i_divisor;
  wire [16:0] trial = {rem_q, num_q[15]};
  wire [16:0] trial_sub = trial - {1'b0, den_q};
  wire q_bit = !trial_sub[16];
  wire [15:0] quot_fix = (neg_num_q ^ neg_den_q) ?
                         (~num_q + 16'h0001) : num_q;
  wire [15:0] rem_fix = neg_num_q ? (~rem_q + 16'h0001) : rem_q;
  wire div_run = !i_div_hold;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      div_state_q <= DIV_IDLE;
      step_q <= 5'h00;
      rem_q <= 16'h0000;
      num_q <= 16'h0000;
      den_q <= 16'h0000;
      neg_num_q <= 1'b0;
      neg_den_q <= 1'b0;
      o_div_busy_q <= 1'b0;
      o_div_done_q <= 1'b0;
      o_quotient_register_q <= 16'h0000;
      o_remainder_register_q <= 16'h0000;
    end else begin
      o_div_done_q <= 1'b0;
      case (div_state_q)
        DIV_IDLE: begin
          if (i_div_start) begin
            rem_q <= dvd_mag[31:16];
            num_q <= dvd_mag[15:0];
            den_q <= dsr_mag;
            neg_num_q <= dvd_neg;
            neg_den_q <= dsr_neg;
            step_q <= 5'h00;
            o_div_busy_q <= 1'b1;
            div_state_q <= DIV_ITER;
          end
        end
        DIV_ITER: begin
          if (div_run) begin
            rem_q <= q_bit ? trial_sub[15:0] : trial[15:0];
            num_q <= {num_q[14:0], q_bit};
            step_q <= step_q + 5'h01;
            if (step_q == `DIV_LAST_STEP) begin
              div_state_q <= DIV_FIX;
            end
          end
        end
        DIV_FIX: begin
          if (div_run) begin
            num_q <= quot_fix;
            rem_q <= rem_fix;
            div_state_q <= DIV_WRITE;
          end
        end
        DIV_WRITE: begin
          if (div_run) begin
            o_quotient_register_q <= num_q;
            o_remainder_register_q <= rem_q;
            o_div_done_q <= 1'b1;
            o_div_busy_q <= 1'b0;
            div_state_q <= DIV_IDLE;
          end
        end
        default: begin
          div_state_q <= DIV_IDLE;
          o_div_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // program address forming
  // ----------------------------------------------------------------
  // execution and window remap stay in the lower half by construction
  wire [23:0] exec_addr = {1'b0, i_instruction_pointer};
  wire [23:0] tbl_addr = {i_table_page_register, i_table_offset};
  wire [23:0] win_addr = {1'b0, i_window_page, i_window_offset};
  wire [23:0] addr_d = i_table_access ? tbl_addr :
                       i_window_access ? win_addr :
                       exec_addr;
  // a window access with the window closed maps to nothing
  wire addr_ok_d = !i_window_access || i_table_access ||
                   control_q[`CC_PROG_WINDOW_BIT];

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_prog_addr_q <= 24'h000000;
      o_prog_addr_ok_q <= 1'b0;
    end else begin
      o_prog_addr_q <= addr_d;
      o_prog_addr_ok_q <= addr_ok_d;
    end
  end

endmodule

`default_nettype wire

// ==== tb/alu_status_checker_sva.sv ====
// port-level assertions for the cpu alu datapath
`timescale 1ns/100ps
`default_nettype none

module alu_status_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // requests
  input wire logic i_op_valid,
  input wire alu_pkg::alu_op_t i_op,
  input wire logic i_div_start,
  input wire logic i_div_hold,
  input wire logic i_repeat_active,
  input wire logic i_nesting_disable,
  input wire logic i_hw_priority_write,
  // answers
  input wire logic o_result_valid_q,
  input wire logic o_div_busy_q,
  input wire logic o_div_done_q,
  input wire logic [15:0] o_alu_flags_word_q,
  input wire logic [15:0] o_core_control_word_q,
  input wire logic [3:0] o_cpu_priority_q,
  input wire logic o_user_irq_blocked_q
);
  import alu_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // ----
  // divider edges that were not stalled
  // ----
  logic [4:0] div_cnt_q;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset)
      div_cnt_q <= 5'h00;
    else if (i_div_start && !o_div_busy_q)
      div_cnt_q <= 5'h00;
    else if (o_div_busy_q && !i_div_hold)
      div_cnt_q <= div_cnt_q + 5'h01;
  end

  property p_repeat;
    !$past(i_reset) |-> o_alu_flags_word_q[4] == $past(i_repeat_active);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat flag lags loop state");
  property p_prio;
    o_cpu_priority_q == {o_core_control_word_q[3], o_alu_flags_word_q[7:5]};
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority not upper bit over low bits");
  property p_blocked;
    o_user_irq_blocked_q ==
      (o_cpu_priority_q > 4'h7 || o_cpu_priority_q[2:0] == 3'h7);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("user interrupt block wrong");
  property p_nest;
    i_nesting_disable && !i_hw_priority_write
      |=> $stable(o_alu_flags_word_q[7:5]);
  endproperty
  a_nest: assert property (p_nest)
    else $error("priority bits changed while locked");
  property p_upper;
    !i_hw_priority_write |=> !$rose(o_core_control_word_q[3]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper priority bit set by software");
  property p_alu_ans;
    i_op_valid && i_op != OP_NONE |=> o_result_valid_q;
  endproperty
  a_alu_ans: assert property (p_alu_ans)
    else $error("alu result not flagged");
  property p_div_len;
    $rose(o_div_done_q) |-> div_cnt_q == 5'h12;
  endproperty
  a_div_len: assert property (p_div_len)
    else $error("divide length wrong");
  property p_div_done;
    o_div_done_q |-> !o_div_busy_q ##1 !o_div_done_q;
  endproperty
  a_div_done: assert property (p_div_done)
    else $error("divide done not a single idle pulse");
endmodule

bind cpu_alu_status_datapath alu_status_checker u_chk (.*);
`default_nettype wire

// ==== tb/seq_stall_model.sv ====
// sequencer stand-in that freezes a running divide for a while
`timescale 1ns/100ps
`default_nettype none

module seq_stall_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // divider handshake
  input wire logic i_busy,
  input wire logic [3:0] i_stall_len,
  output logic o_hold
);
  logic [4:0] age_q;
  logic [3:0] left_q;
  wire logic stall_now;
  assign stall_now = i_busy && age_q >= 5'h04 && left_q != 4'h0;

  // a pending interrupt pauses the divide once it has been busy four cycles
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      age_q <= 5'h00;
      left_q <= 4'h0;
      o_hold <= 1'b0;
    end else begin
      age_q <= i_busy ? age_q + 5'h01 : 5'h00;
      left_q <= !i_busy ? i_stall_len : left_q - {3'h0, stall_now};
      o_hold <= stall_now;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_cpu_alu_status_datapath.sv ====
// self-checking bench for the cpu alu datapath
`timescale 1ns/100ps
`default_nettype none

module test_cpu_alu_status_datapath;
  import alu_pkg::*;
  logic i_clock, i_reset, i_op_valid, i_byte_mode, i_mul_valid;
  logic i_div_start, i_div_signed, i_div_long, i_div_hold;
  logic i_flags_write, i_control_write, i_nesting_disable;
  logic i_repeat_active, i_hw_priority_write, i_table_access;
  logic i_window_access, o_result_valid_q, o_product_valid_q;
  logic o_div_busy_q, o_div_done_q, o_user_irq_blocked_q, o_prog_addr_ok_q;
  alu_op_t i_op;
  mul_mode_t i_mul_mode;
  logic [3:0] i_shift_amount, i_hw_priority, o_cpu_priority_q, stall_len;
  logic [4:0] i_mul_literal;
  logic [7:0] i_table_page_register, i_window_page;
  logic [14:0] i_window_offset;
  logic [15:0] i_op_a, i_op_b, i_mul_a, i_mul_b, i_dividend_even;
  logic [15:0] i_dividend_odd, i_divisor, i_flags_wdata, i_control_wdata;
  logic [15:0] i_table_offset, o_result_q, o_quotient_register_q;
  logic [15:0] o_remainder_register_q, o_alu_flags_word_q;
  logic [15:0] o_core_control_word_q;
  logic [22:0] i_instruction_pointer;
  logic [23:0] o_prog_addr_q;
  logic [31:0] o_product_q;
  int mismatches = 0;
  int compares = 0;

  cpu_alu_status_datapath u_dut (.*);
  seq_stall_model u_seq (.i_clock, .i_reset, .i_busy(o_div_busy_q),
    .i_stall_len(stall_len), .o_hold(i_div_hold));
  always #2.5 i_clock = ~i_clock;

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // quiet edge after the strobe so two strobes never merge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
    @(negedge i_clock);
  endtask

  // shift count rides in the low bits of b
  task automatic alu(input alu_op_t op, input logic [15:0] a, b, res,
      input logic [8:0] fl, input logic bm = 1'b0);
    i_op = op;
    i_byte_mode = bm;
    i_op_a = a;
    i_op_b = b;
    i_shift_amount = b[3:0];
    i_op_valid = 1'b1;
    @(negedge i_clock);
    check(o_result_q, res);
    check(o_alu_flags_word_q, fl);
    check(o_result_valid_q, 1'b1);
  endtask

  task automatic mul(input mul_mode_t m, input logic [15:0] a, b,
      input logic [4:0] lit, input logic [31:0] p);
    i_mul_mode = m;
    i_mul_a = a;
    i_mul_b = b;
    i_mul_literal = lit;
    i_mul_valid = 1'b1;
    @(negedge i_clock);
    check(o_product_q, p);
    check(o_product_valid_q, 1'b1);
  endtask

  // md is {signed, long}; a second start mid-run must be ignored
  task automatic div(input logic [1:0] md, input logic [31:0] dd,
      input logic [15:0] dv, input logic [3:0] st, input logic [15:0] q, r);
    int k;
    {i_div_signed, i_div_long} = md;
    {i_dividend_odd, i_dividend_even} = dd;
    i_divisor = dv;
    stall_len = st;
    i_div_start = 1'b1;
    @(negedge i_clock);
    i_div_start = 1'b0;
    k = 1;
    while (o_div_done_q !== 1'b1 && k < 60) begin
      if (k == 3) begin
        i_div_start = 1'b1;
        i_divisor = 16'h1;
      end
      if (k == 4)
        i_div_start = 1'b0;
      @(negedge i_clock);
      k++;
    end
    if (k >= 60) begin
      mismatches++;
      results();
    end
    check(k, 19 + st);
    check(o_quotient_register_q, q);
    check(o_remainder_register_q, r);
  endtask

  initial begin
    {i_clock, i_op_valid, i_byte_mode, i_mul_valid, i_div_start} = '0;
    {i_div_signed, i_div_long, i_flags_write, i_control_write} = '0;
    {i_nesting_disable, i_repeat_active, i_hw_priority_write} = '0;
    {i_table_access, i_window_access, i_shift_amount, i_hw_priority} = '0;
    {stall_len, i_mul_literal, i_table_page_register, i_window_page} = '0;
    {i_window_offset, i_op_a, i_op_b, i_mul_a, i_mul_b} = '0;
    {i_dividend_even, i_dividend_odd, i_divisor, i_flags_wdata} = '0;
    {i_control_wdata, i_table_offset, i_instruction_pointer} = '0;
    i_op = OP_NONE;
    i_mul_mode = MUL_SS;
    i_reset = 1'b1;
    repeat (20) @(negedge i_clock);
    i_reset = 1'b0;
    check(o_alu_flags_word_q, 16'h0);
    check(o_core_control_word_q, 16'h0);
    // ----
    // alu, back to back
    // ----
    alu(OP_ADD, 16'h7fff, 16'h1, 16'h8000, 9'h10c);
    alu(OP_ADD, 16'h120f, 16'h1, 16'h1210, 9'h100, 1'b1);
    alu(OP_SUB, 16'h5, 16'h5, 16'h0, 9'h103);
    alu(OP_AND, 16'h8000, 16'hffff, 16'h8000, 9'h109);
    alu(OP_IOR, 16'h0, 16'h0, 16'h0, 9'h103);
    alu(OP_ARITH_RIGHT_SHIFT, 16'h8000, 16'hf, 16'hffff, 9'h109);
    alu(OP_LEFT_SHIFT, 16'h8001, 16'h1, 16'h2, 9'h101);
    alu(OP_LOGICAL_RIGHT_SHIFT, 16'h2, 16'h1, 16'h1, 9'h100);
    alu(OP_LOGICAL_RIGHT_SHIFT, 16'h8000, 16'hf, 16'h1, 9'h100);
    alu(OP_SUB, 16'h0, 16'h1, 16'hffff, 9'h008);
    alu(OP_ADD, 16'hffff, 16'h1, 16'h0, 9'h103);
    alu(OP_ADDC, 16'h0, 16'h0, 16'h1, 9'h000);
    alu(OP_SUBB, 16'h0, 16'h0, 16'hffff, 9'h008);
    alu(OP_ADD, 16'h0080, 16'h80, 16'h0, 9'h007, 1'b1);
    alu(OP_XOR, 16'hffff, 16'hff, 16'hff00, 9'h00d);
    alu(OP_ARITH_RIGHT_SHIFT, 16'h80, 16'h1, 16'hc0, 9'hc, 1'b1);
    i_op_valid = 1'b0;
    // ----
    // multiplier modes
    // ----
    mul(MUL_SS, 16'hffff, 16'hffff, 5'h0, 32'h1);
    mul(MUL_UU, 16'hffff, 16'hffff, 5'h0, 32'hfffe0001);
    mul(MUL_SU, 16'hffff, 16'h2, 5'h0, 32'hfffffffe);
    mul(MUL_US, 16'hffff, 16'hfffe, 5'h0, 32'hfffe0002);
    mul(MUL_S_LIT, 16'hffff, 16'h0, 5'h1f, 32'hffffffe1);
    mul(MUL_U_LIT, 16'hffff, 16'h0, 5'h1f, 32'h1effe1);
    mul(MUL_BYTE_UU, 16'h12ff, 16'h34ff, 5'h0, 32'hfe01);
    i_mul_valid = 1'b0;
    // ----
    // divider, with and without stalls
    // ----
    div(2'h1, 32'h10000, 16'h2, 4'h0, 16'h8000, 16'h0);
    div(2'h0, 32'hffff0064, 16'h7, 4'h3, 16'he, 16'h2);
    div(2'h2, 32'h5555fff9, 16'h2, 4'h2, 16'hfffd, 16'hffff);
    div(2'h3, 32'hfffe7960, 16'h7, 4'h0, 16'hc833, 16'hfffb);
    // ----
    // status and control words
    // ----
    i_flags_wdata = 16'hffff;
    pulse(i_flags_write);
    check(o_alu_flags_word_q, 16'h01ef);
    check(o_user_irq_blocked_q, 1'b1);
    i_nesting_disable = 1'b1;
    i_flags_wdata = 16'h0;
    pulse(i_flags_write);
    check(o_alu_flags_word_q, 16'h00e0);
    i_nesting_disable = 1'b0;
    i_control_wdata = 16'hffff;
    pulse(i_control_write);
    check(o_core_control_word_q, 16'h0004);
    i_hw_priority = 4'hb;
    pulse(i_hw_priority_write);
    check(o_core_control_word_q, 16'h000c);
    check(o_cpu_priority_q, 4'hb);
    i_control_wdata = 16'h0004;
    pulse(i_control_write);
    check(o_cpu_priority_q, 4'h3);
    check(o_user_irq_blocked_q, 1'b0);
    i_repeat_active = 1'b1;
    pulse(i_flags_write);
    check(o_alu_flags_word_q, 16'h0010);
    i_repeat_active = 1'b0;
    // ----
    // program address forming
    // ----
    i_instruction_pointer = 23'h7fffff;
    @(negedge i_clock);
    check(o_prog_addr_q, 24'h7fffff);
    i_table_access = 1'b1;
    i_table_page_register = 8'h80;
    i_table_offset = 16'h6;
    @(negedge i_clock);
    check(o_prog_addr_q, 24'h800006);
    i_table_access = 1'b0;
    i_window_access = 1'b1;
    i_window_page = 8'h12;
    i_window_offset = 15'h7ffe;
    @(negedge i_clock);
    check({o_prog_addr_ok_q, o_prog_addr_q}, 25'h1097ffe);
    i_control_wdata = 16'h0;
    pulse(i_control_write);
    check(o_prog_addr_ok_q, 1'b0);
    results();
  end
endmodule
`default_nettype wire
